//--- verilog/psf_consts.svh
// Constants of the program status flags block
`ifndef PSF_CONSTS_SVH
`define PSF_CONSTS_SVH

`define PSF_SFR_ADDR      8'hD0
`define PSF_RESET_VAL     8'h00
`define PSF_BIT_CARRY     3'h7
`define PSF_BIT_NIBBLE    3'h6
`define PSF_BIT_USER_A    3'h5
`define PSF_BIT_BANK_HI   3'h4
`define PSF_BIT_BANK_LO   3'h3
`define PSF_BIT_RANGE     3'h2
`define PSF_BIT_USER_B    3'h1
`define PSF_BIT_PARITY    3'h0
`define PSF_BITADDR_BASE  5'h1A
`define PSF_ZERO_BYTE     8'h00

`endif

//--- verilog/psf_pkg.sv
// Types of the program status flags block
package psf_pkg;
    typedef enum logic [2:0] {
        PSF_OP_NONE = 3'b000,
        PSF_OP_ADD  = 3'b001,
        PSF_OP_ADDC = 3'b010,
        PSF_OP_SUBB = 3'b011,
        PSF_OP_MUL  = 3'b100,
        PSF_OP_DIV  = 3'b101
    } psf_op_t;
endpackage

//--- verilog/psf_bank_addr.sv
// Register bank address forming for the low internal RAM
`timescale 1ns/1ns
`default_nettype none
`include "psf_consts.svh"
module psf_bank_addr #(
    parameter int REG_BITS  = 3,
    parameter int BANK_BITS = 2
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic [BANK_BITS-1:0]          bankSelect,
    input  wire logic [REG_BITS-1:0]           regIndex,
    output var  logic [BANK_BITS+REG_BITS-1:0] bankRegAddr
);
    initial begin
        if (REG_BITS != 3 || BANK_BITS != 2) begin
            $error("psf_bank_addr: four banks of eight registers only");
        end
    end

    wire logic [BANK_BITS+REG_BITS-1:0] bankRegAddr_next;

    assign bankRegAddr_next = {bankSelect, regIndex};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bankRegAddr <= '0;
        end else begin
            bankRegAddr <= bankRegAddr_next;
        end
    end
endmodule // psf_bank_addr
`default_nettype wire

//--- verilog/psf_status_flags.sv
// Program status flags word with arithmetic flag update and bank selection
//
// Function
// - Bit 7 carry set on add carry or subtract borrow, else cleared.
// - Bit 6 nibble carry set on carry into or borrow from high nibble.
// - Bits 5 and 1 are software flags, hardware never changes them.
// - Bits 4:3 choose register bank 0 to 3.
// - Bit 2 set on signed overflow of add, add with carry, subtract.
// - Bit 2 also set when multiply product exceeds 255.
// - Add, subtract, multiply, divide clear bit 2 when no overflow.
// - Locations 0x00 to 0x1F form four banks of eight registers.
`timescale 1ns/1ns
`default_nettype none
`include "psf_consts.svh"
module psf_status_flags
    import psf_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [7:0]    sfrAddr,
    input  wire logic          sfrWrite,
    input  wire logic [7:0]    sfrWrData,
    input  wire logic          sfrRead,
    input  wire logic          bitWrite,
    input  wire logic [7:0]    bitAddr,
    input  wire logic          bitWrData,
    input  wire logic          arithValid,
    input  wire psf_op_t       arithOp,
    input  wire logic [7:0]    operandA,
    input  wire logic [7:0]    operandB,
    input  wire logic [7:0]    accumulator,
    input  wire logic [2:0]    regIndex,
    output var  logic [7:0]    sfrRdData,
    output var  logic [7:0]    program_status_flags,
    output var  logic [4:0]    bankRegAddr
);
    initial begin
        if (DATA_W != 8) begin
            $error("psf_status_flags: byte-wide datapath only");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic       parity_reg;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;

    ////////////////////////////////////////////////////////////////////////////
    // Access decode

    wire logic       sfrHit;
    wire logic       byteWr;
    wire logic       bitHit;
    wire logic [4:0] bitByte;
    wire logic [2:0] bitPos;
    wire logic [7:0] bitWrEn;
    wire logic [7:0] swFlags;

    assign sfrHit  = (sfrAddr == `PSF_SFR_ADDR);
    assign byteWr  = sfrWrite && sfrHit;
    assign bitByte = bitAddr[7:3];
    assign bitPos  = bitAddr[2:0];
    assign bitHit  = bitWrite && (bitByte == `PSF_BITADDR_BASE);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bit
            assign bitWrEn[gi] = bitHit && (bitPos == 3'(gi));
            assign swFlags[gi] = byteWr      ? sfrWrData[gi] :
                                 bitWrEn[gi] ? bitWrData     : flags_reg[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic flag computation

    wire logic        opAdd;
    wire logic        opAddc;
    wire logic        opSubb;
    wire logic        opMul;
    wire logic        opDiv;
    wire logic        carryIn;
    wire logic        isAdd;
    wire logic        isSub;
    wire logic        isMul;
    wire logic        isDiv;
    wire logic        isArith;
    wire logic [8:0]  addSum;
    wire logic [4:0]  addNib;
    wire logic [8:0]  subDiff;
    wire logic [4:0]  subNib;
    wire logic [15:0] product;
    wire logic        addOv;
    wire logic        subOv;
    wire logic        mulOv;
    wire logic        divOv;
    wire logic        newCarry;
    wire logic        newNibble;
    wire logic        newRange;

    assign opAdd   = (arithOp == PSF_OP_ADD);
    assign opAddc  = (arithOp == PSF_OP_ADDC);
    assign opSubb  = (arithOp == PSF_OP_SUBB);
    assign opMul   = (arithOp == PSF_OP_MUL);
    assign opDiv   = (arithOp == PSF_OP_DIV);
    // Add with carry and subtract chain the carry left before this edge
    assign carryIn = opAdd ? 1'b0 : flags_reg[`PSF_BIT_CARRY];
    assign isAdd   = arithValid && (opAdd || opAddc);
    assign isSub   = arithValid && opSubb;
    assign isMul   = arithValid && opMul;
    assign isDiv   = arithValid && opDiv;
    assign isArith = isAdd || isSub || isMul || isDiv;

    assign addSum  = {1'b0, operandA} + {1'b0, operandB} + {8'h00, carryIn};
    assign addNib  = {1'b0, operandA[3:0]} + {1'b0, operandB[3:0]} + {4'h0, carryIn};
    assign subDiff = {1'b0, operandA} - {1'b0, operandB} - {8'h00, carryIn};
    assign subNib  = {1'b0, operandA[3:0]} - {1'b0, operandB[3:0]} - {4'h0, carryIn};
    assign product = {8'h00, operandA} * {8'h00, operandB};

    assign addOv = (operandA[7] == operandB[7]) && (addSum[7] != operandA[7]);
    assign subOv = (operandA[7] != operandB[7]) && (subDiff[7] != operandA[7]);
    assign mulOv = (product[15:8] != `PSF_ZERO_BYTE);
    assign divOv = (operandB == `PSF_ZERO_BYTE);

    assign newCarry  = isAdd ? addSum[8] : isSub ? subDiff[8] : 1'b0;
    assign newNibble = isAdd ? addNib[4] : isSub ? subNib[4] : 1'b0;
    assign newRange  = isAdd ? addOv : isSub ? subOv : isMul ? mulOv : divOv;

    ////////////////////////////////////////////////////////////////////////////
    // Next flag word

    always_comb begin
        flags_next = swFlags;
        if (isArith) begin
            flags_next[`PSF_BIT_CARRY]  = newCarry;
            flags_next[`PSF_BIT_NIBBLE] = newNibble;
            flags_next[`PSF_BIT_RANGE]  = newRange;
        end
        flags_next[`PSF_BIT_USER_A] = swFlags[`PSF_BIT_USER_A];
        flags_next[`PSF_BIT_USER_B] = swFlags[`PSF_BIT_USER_B];
        flags_next[`PSF_BIT_PARITY] = 1'b0;
    end

    wire logic       accParity;
    wire logic [7:0] wordNow;
    wire logic [7:0] word_next;

    assign accParity = ^accumulator;
    assign wordNow   = {flags_reg[`PSF_BIT_CARRY:`PSF_BIT_USER_B], parity_reg};
    assign word_next = {flags_next[`PSF_BIT_CARRY:`PSF_BIT_USER_B], accParity};

    // Read returns the word as it stands before this cycle's update
    assign rdData_next = (sfrRead && sfrHit) ? wordNow : `PSF_ZERO_BYTE;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_reg <= `PSF_RESET_VAL;
        end else begin
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            parity_reg <= 1'b0;
        end else begin
            parity_reg <= accParity;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_reg <= `PSF_ZERO_BYTE;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            program_status_flags <= `PSF_RESET_VAL;
        end else begin
            program_status_flags <= word_next;
        end
    end

    assign sfrRdData = rdData_reg;

    wire logic [1:0] bankSelect;

    assign bankSelect = flags_reg[`PSF_BIT_BANK_HI:`PSF_BIT_BANK_LO];

    psf_bank_addr #(
        .REG_BITS  (3),
        .BANK_BITS (2)
    ) psf_bank_addr_inst (
        .clk         (clk),
        .rst_n       (rst_n),
        .bankSelect  (bankSelect),
        .regIndex    (regIndex),
        .bankRegAddr (bankRegAddr)
    );
endmodule // psf_status_flags
`default_nettype wire

//--- tb/psf_checker.sv
// Assertion checker of the program status flags block
`timescale 1ns/1ns
`default_nettype none
module psf_checker
    import psf_pkg::*;
(
    input wire logic       clk, rst_n, sfrWrite, sfrRead, bitWrite, arithValid,
    input wire psf_op_t    arithOp,
    input wire logic [7:0] sfrAddr, operandA, operandB, accumulator, sfrRdData,
    input wire logic [7:0] program_status_flags,
    input wire logic [2:0] regIndex,
    input wire logic [4:0] bankRegAddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire [7:0] w = program_status_flags;
    wire [8:0] sm = operandA + operandB;
    wire [4:0] nb = operandA[3:0] + operandB[3:0];
    wire [15:0] pr = operandA * operandB;
    wire [8:0] sd = {1'b0, operandA} - {1'b0, operandB} - {8'h00, w[7]};
    wire cy = sm[8];
    wire hc = nb[4];
    wire ov = (operandA[7] == operandB[7]) && (sm[7] != operandA[7]);
    wire mo = |pr[15:8];
    wire par = ^accumulator;
    wire add = arithValid && arithOp == PSF_OP_ADD;
    wire [3:0] sw = {w[5:3], w[1]};
    wire [4:0] ba = {w[4:3], regIndex};
    property p_car; add |=> w[7] == $past(cy); endproperty
    a_car: assert property (p_car) else $error("carry bad");
    property p_sbc; arithValid && arithOp == PSF_OP_SUBB |=> w[7] == $past(sd[8]); endproperty
    a_sbc: assert property (p_sbc) else $error("borrow bad");
    property p_nib; add |=> w[6] == $past(hc); endproperty
    a_nib: assert property (p_nib) else $error("nibble bad");
    property p_ovf; add |=> w[2] == $past(ov); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow bad");
    property p_mul; arithValid && arithOp == PSF_OP_MUL |=> w[2] == $past(mo); endproperty
    a_mul: assert property (p_mul) else $error("mul range bad");
    property p_div; arithValid && arithOp == PSF_OP_DIV && operandB != 8'h00 |=> !w[2]; endproperty
    a_div: assert property (p_div) else $error("div range bad");
    property p_sw; !sfrWrite && !bitWrite |=> $stable(sw); endproperty
    a_sw: assert property (p_sw) else $error("soft bits moved");
    property p_bank; $past(rst_n) |-> bankRegAddr == $past(ba); endproperty
    a_bank: assert property (p_bank) else $error("bank addr bad");
    property p_par; $past(rst_n) |-> w[0] == $past(par); endproperty
    a_par: assert property (p_par) else $error("parity bad");
    property p_rd; sfrRead && sfrAddr == 8'hD0 |=> sfrRdData == $past(w); endproperty
    a_rd: assert property (p_rd) else $error("read bad");
    c_add: cover property (add && ov);
    c_mul: cover property (arithValid && arithOp == PSF_OP_MUL && mo);
    c_rd: cover property (sfrRead && sfrAddr == 8'hD0);
endmodule // psf_checker
bind psf_status_flags psf_checker psf_checker_inst (.*);
`default_nettype wire

//--- tb/psf_exec_model.sv
// Execution datapath model driving arithmetic requests
`timescale 1ns/1ns
`default_nettype none
module psf_exec_model
    import psf_pkg::*;
(
    input  wire logic       clk,
    output var  logic       arithValid,
    output var  psf_op_t    arithOp,
    output var  logic [7:0] operandA,
    output var  logic [7:0] operandB,
    output var  logic [7:0] accumulator
);
    initial begin
        {arithValid, operandA, operandB, accumulator} = '0;
        arithOp = PSF_OP_NONE;
    end
    task automatic step(input logic v, input psf_op_t op, input logic [7:0] a, b, acc);
        {arithValid, operandA, operandB, accumulator} <= {v, a, b, acc};
        arithOp <= op;
        @(posedge clk);
    endtask
endmodule // psf_exec_model
`default_nettype wire

//--- tb/test_processor_status_flags.sv
// Self-checking bench of the program status flags block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin nTests++; if ((s) !== (e)) begin errTotal++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module test_processor_status_flags;
    import psf_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0, cin;
    logic bitWrite = 1'b0, bitWrData = 1'b0, arithValid;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00, operandA, operandB;
    logic [7:0] accumulator, sfrRdData, program_status_flags, ew = 8'h00, rdExp, a, b, ad, ba;
    logic [4:0] bankRegAddr, bkExp;
    logic [7:0] ewQ = 8'h00, rdQ = 8'h00, ewC = 8'h00, rdC = 8'h00;
    logic [4:0] bkQ = 5'h00, bkC = 5'h00;
    logic vldQ = 1'b0, vldC = 1'b0;
    logic [2:0] regIndex = 3'h0;
    logic [31:0] seed = 32'h0000_48CE, bus;
    psf_op_t arithOp, op;
    int errTotal = 0, nTests = 0;
    wire [7:0] pw = program_status_flags;
    psf_status_flags psf_status_flags_inst (.*);
    psf_exec_model psf_exec_model_inst (.*);
    initial forever #4 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [2:0] flg(input psf_op_t o, input logic [7:0] x, y, input logic c);
        logic [8:0] r;
        logic [4:0] h;
        logic [15:0] p;
        r = (o == PSF_OP_SUBB) ? {1'b0, x} - y - c : {1'b0, x} + y + (o == PSF_OP_ADDC & c);
        h = (o == PSF_OP_SUBB) ? {1'b0, x[3:0]} - y[3:0] - c
                               : {1'b0, x[3:0]} + y[3:0] + (o == PSF_OP_ADDC & c);
        p = x * y;
        if (o == PSF_OP_MUL) return {2'b00, |p[15:8]};
        if (o == PSF_OP_DIV) return {2'b00, y == 8'h00};
        return {r[8], h[4], (x[7] ^ r[7]) & (x[7] ^ y[7] ^ (o != PSF_OP_SUBB))};
    endfunction
    task automatic chk;
        `CHK("carry", ewC[7], pw[7])
        `CHK("nibble", ewC[6], pw[6])
        `CHK("soft", {ewC[5:3], ewC[1]}, {pw[5:3], pw[1]})
        `CHK("range", ewC[2], pw[2])
        `CHK("parity", ewC[0], pw[0])
        `CHK("rdata", rdC, sfrRdData)
        `CHK("bank", bkC, bankRegAddr)
    endtask
    task automatic endSim;
        $display("Checks %0d errors %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Expectations trail the stimulus by one edge and are checked mid-cycle
    always @(posedge clk) {ewC, rdC, bkC, vldC} <= {ewQ, rdQ, bkQ, vldQ};
    always @(negedge clk) if (vldC) chk();
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            seed = xs(seed);
            bus = xs(~seed);
            op = psf_op_t'(seed[2:0] % 3'd6);
            a = (i % 5 == 0) ? 8'h7F : seed[15:8];
            b = (i % 7 == 0) ? 8'h00 : seed[23:16];
            ad = bus[0] ? 8'hD0 : bus[15:8];
            ba = bus[1] ? {5'h1A, bus[4:2]} : bus[23:16];
            {sfrAddr, sfrWrData, bitAddr, bitWrData} <= {ad, bus[31:24], ba, bus[5]};
            {sfrWrite, bitWrite, sfrRead} <= {bus[7:6] == 2'b11, bus[8], bus[9]};
            regIndex <= bus[12:10];
            rdExp = (bus[9] && ad == 8'hD0) ? ew : 8'h00;
            bkExp = {ew[4:3], bus[12:10]};
            cin = ew[7];
            if (bus[7:6] == 2'b11 && ad == 8'hD0) ew[7:1] = bus[31:25];
            else if (bus[8] && ba[7:3] == 5'h1A && ba[2:0] != 3'h0) ew[ba[2:0]] = bus[5];
            if (seed[3] && op != PSF_OP_NONE) {ew[7:6], ew[2]} = flg(op, a, b, cin);
            ew[0] = ^seed[31:24];
            {ewQ, rdQ, bkQ, vldQ} <= {ew, rdExp, bkExp, 1'b1};
            psf_exec_model_inst.step(seed[3], op, a, b, seed[31:24]);
        end
        vldQ <= 1'b0;
        repeat (2) @(posedge clk);
        endSim();
    end
    initial begin
        #(8 * 1000);
        errTotal++;
        endSim();
    end
endmodule // test_processor_status_flags
`default_nettype wire
